/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the timed I/O port
// Assumes: Port clock block 0 ticks every ref_clk cycle
// Notes:   Sticky event status read back to avoid pulse races
`timescale 1ns/100ps
module tb_top;
    logic        ref_clk = 1'b0;     // 10 MHz
    logic        reset = 1'b1;       // Synchronous, high
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] pin_in, pin_out, pin_oe_n;
    logic [31:0] pin_taken = 32'h0000_0000;
    logic        link_en = 1'b0;
    logic        clock_pin, stb_in, stb_out, port_event;
    logic [31:0] ext_val = 32'h0000_0000; // Outside drive levels
    logic        ext_strobe = 1'b0;
    logic        clk_run = 1'b0;
    int          err_total = 0;
    int          tests_run = 0;
    always #50 ref_clk = ~ref_clk;
    tio_port dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_taken(pin_taken), .link_en(link_en), .clock_pin(clock_pin),
        .strobe_input_qualifier(stb_in), .strobe_output_qualifier(stb_out), .port_event(port_event));
    tio_pin_model pins (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
        .ext_strobe(ext_strobe), .clk_run(clk_run), .pin_in(pin_in),
        .strobe_input_qualifier(stb_in), .clock_pin(clock_pin));
    // Word comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus write: waits for waitrequest low at an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge ref_clk);
        // Held until waitrequest is seen low; only the watchdog ends a hang
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        avs_write <= 1'b0;
    endtask
    // Bus read: data taken at the edge where waitrequest is low
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        avs_read <= 1'b1;
        avs_address <= a;
        @(posedge ref_clk);
        // Wait states counted; only the watchdog ends a hung read
        while (avs_waitrequest !== 1'b0) begin
            n++;
            @(posedge ref_clk);
        end
        d = avs_readdata;
        avs_read <= 1'b0;
        chk(32'(n), 32'h1);
    endtask
    // Wait until a flag is seen high at an edge
    task automatic wait_hi(ref logic f);
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (f === 1'b1) break;
        end
        if (n == 20) chk(32'h0, 32'h1);
    endtask
    // Reset state, unmapped place
    task automatic t_reset;
        logic [31:0] d;
        chk(pin_oe_n, 32'hFFFF_FFFF);
        rd(tio_pkg::ADDR_CTRL, d);
        chk(d, 32'h0000_0000);
        wr(8'h1C, 32'hDEAD_BEEF);
        rd(8'h1C, d);
        chk(d, 32'h0000_0000);
    endtask
    // Full-width push-pull word with strobe, then pin sharing
    task automatic t_out32;
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0223);
        wr(tio_pkg::ADDR_DATA, 32'hA5C3_0F12);
        wait_hi(stb_out);
        chk(pin_out, 32'hA5C3_0F12);
        chk(pin_oe_n, 32'h0000_0000);
        @(posedge ref_clk) pin_taken <= 32'h0000_00F0;
        repeat (3) @(posedge ref_clk);
        chk(pin_oe_n, 32'h0000_00F0);
        @(posedge ref_clk) link_en <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(pin_oe_n, 32'hFFFF_FFFF);
        @(posedge ref_clk) begin
            link_en <= 1'b0;
            pin_taken <= 32'h0000_0000;
        end
    endtask
    // Open drain: zeros pull low, ones float
    task automatic t_drain;
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0227);
        wr(tio_pkg::ADDR_DATA, 32'h0000_FFFF);
        wait_hi(stb_out);
        chk(pin_oe_n, 32'h0000_FFFF);
        chk(pin_out, 32'h0000_0000);
    endtask
    // Byte port sends a word as four slices, low first
    task automatic t_out8;
        int i;
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0213);
        wr(tio_pkg::ADDR_DATA, 32'h4433_2211);
        for (i = 0; i < 4; i++) begin
            wait_hi(stb_out);
            chk({24'h0, pin_out[7:0]}, 32'(8'h11 * (i + 1)));
        end
    endtask
    // Output held until counter meets target, stamp equals target
    task automatic t_timed;
        logic [31:0] c, d;
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0023);
        rd(tio_pkg::ADDR_COUNT, c);
        c = (c + 32'h1E) & 32'h0000_FFFF;
        wr(tio_pkg::ADDR_TIME, c);
        wr(tio_pkg::ADDR_DATA, 32'h1234_5678);
        rd(tio_pkg::ADDR_STATUS, d);
        chk(d & 32'h2, 32'h2);
        repeat (40) @(posedge ref_clk);
        rd(tio_pkg::ADDR_STATUS, d);
        chk(d & 32'h2, 32'h0);
        rd(tio_pkg::ADDR_STAMP, d);
        chk(d & 32'h0000_FFFF, c);
    endtask
    // Strobed byte input builds a word and raises an event
    task automatic t_in8;
        int i;
        logic [31:0] d;
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0211);
        wr(tio_pkg::ADDR_STATUS, 32'h0000_0004);
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk) begin
                ext_val <= 32'(8'hB0 + i);
                ext_strobe <= 1'b1;
            end
            @(posedge ref_clk) ext_strobe <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
        rd(tio_pkg::ADDR_STATUS, d);
        chk(d & 32'h5, 32'h5);
        rd(tio_pkg::ADDR_DATA, d);
        chk(d, 32'hB3B2_B1B0);
    endtask
    // Equal and not-equal conditions on pins
    task automatic t_cond;
        logic [31:0] d;
        @(posedge ref_clk) ext_val <= 32'h0000_0000;
        wr(tio_pkg::ADDR_COND, 32'h0000_005A);
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0411);
        wr(tio_pkg::ADDR_STATUS, 32'h0000_0004);
        repeat (5) @(posedge ref_clk);
        rd(tio_pkg::ADDR_STATUS, d);
        chk(d & 32'h4, 32'h0);
        @(posedge ref_clk) ext_val <= 32'h0000_005A;
        wait_hi(port_event);
        // Read at once: after a hit the port falls back to free sampling
        rd(tio_pkg::ADDR_DATA, d);
        chk(d, 32'h0000_005A);
        rd(tio_pkg::ADDR_STATUS, d);
        chk(d & 32'h4, 32'h4);
        // Not-equal mode: equal pins wait, differing pins fire
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0811);
        @(posedge ref_clk) ext_val <= 32'h0000_003C;
        wait_hi(port_event);
        rd(tio_pkg::ADDR_DATA, d);
        chk(d, 32'h0000_003C);
    endtask
    // Block 1 fed from clock pin, divided by two
    task automatic t_clkblk;
        logic [31:0] c0, c1;
        wr(tio_pkg::ADDR_CLKCFG, 32'h0000_0101);
        wr(tio_pkg::ADDR_CTRL, 32'h0000_0041);
        rd(tio_pkg::ADDR_COUNT, c0);
        @(posedge ref_clk) clk_run <= 1'b1;
        repeat (40) @(posedge ref_clk);
        clk_run <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(tio_pkg::ADDR_COUNT, c1);
        chk((c1 - c0) & 32'h0000_FFFF, 32'h0A);
    endtask
    // Verdict and end of run
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog, well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        end_of_test;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_reset;
        t_out32;
        t_drain;
        t_out8;
        t_timed;
        t_in8;
        t_cond;
        t_clkblk;
        end_of_test;
    end
endmodule

/* File: dv/tio_pin_model.sv */
// Purpose: Outside hardware on the pins of the timed I/O port
// Assumes: Pull-down on every pin, clock pin synchronous to ref_clk
// Notes:   Bench steers drive levels, strobe and clock run
`timescale 1ns/100ps
module tio_pin_model (
    // Clock
    input  wire logic        ref_clk,
    // From the port
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe_n,
    // Bench controls
    input  wire logic [31:0] ext_val,
    input  wire logic        ext_strobe,
    input  wire logic        clk_run,
    // Back to the port
    output logic      [31:0] pin_in,
    output logic             strobe_input_qualifier,
    output logic             clock_pin
);
    // Port wins where it drives, else outside level; zero means pulled down
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_val);
    assign strobe_input_qualifier = ext_strobe;
    // application clock on pin
    // Stands still outside a burst so no stray edges get counted
    initial clock_pin = 1'b0;
    always @(posedge ref_clk) begin
        if (clk_run) begin
            clock_pin <= ~clock_pin;
        end
    end
endmodule

/* File: logic/tio_clkblk.sv */
// Purpose: One programmable clock block producing a tick
// Assumes: Clock pin is synchronous to ref_clk
// Notes:   Tick rate is source rate over divide plus one
`timescale 1ns/100ps
module tio_clkblk (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Configuration
    input  wire logic       src_pin,
    input  wire logic [7:0] divide,
    // Source pin and tick
    input  wire logic       clock_pin,
    output logic            tick
);
    // Whole state of the block
    typedef struct packed {
        logic       prev;
        logic [7:0] cnt;
        logic       tick;
    } tio_clk_s;

    tio_clk_s st;       // Registered state
    tio_clk_s next_st;  // Next state
    logic     src_edge; // One source edge

    // Source edge and divider
    always_comb begin
        next_st = st;
        next_st.prev = clock_pin;
        next_st.tick = 1'b0;
        // R17 pin as source
        src_edge = src_pin ? (clock_pin && !st.prev) : 1'b1;
        // R16 R18 optional division
        if (src_edge) begin
            if (st.cnt >= divide) begin
                next_st.cnt  = 8'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule

/* File: logic/tio_pkg.sv */
// Purpose: Shared constants of the timed I/O port
// Assumes: Avalon-MM byte addresses, one 32-bit word each
// Notes:   Control state resets to zero
package tio_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DATA   = 8'h04;
    localparam logic [7:0] ADDR_TIME   = 8'h08;
    localparam logic [7:0] ADDR_COUNT  = 8'h0C;
    localparam logic [7:0] ADDR_STAMP  = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_COND   = 8'h18;
    localparam logic [7:0] ADDR_CLKCFG = 8'h20;
    // Control field positions
    localparam int CTRL_EN     = 0;
    localparam int CTRL_DIR    = 1;
    localparam int CTRL_OD     = 2;
    localparam int CTRL_WID    = 3;
    localparam int CTRL_CSEL   = 6;
    localparam int CTRL_STROBE = 9;
    localparam int CTRL_COND   = 10;
    // Status field positions
    localparam int STAT_VALID = 0;
    localparam int STAT_PEND  = 1;
    localparam int STAT_EVENT = 2;
    localparam int STAT_BUSY  = 3;
    // Clock block config fields
    localparam int CLK_SRCPIN = 8;
    localparam int NUM_CLKBLK = 6;
    // Width codes: 1, 4, 8, 16, 32 bits
    localparam logic [2:0] WID_1  = 3'h0;
    localparam logic [2:0] WID_4  = 3'h1;
    localparam logic [2:0] WID_8  = 3'h2;
    localparam logic [2:0] WID_16 = 3'h3;
    localparam logic [2:0] WID_32 = 3'h4;
    // Condition modes
    localparam logic [1:0] COND_NONE = 2'h0;
    localparam logic [1:0] COND_EQ   = 2'h1;
    localparam logic [1:0] COND_NEQ  = 2'h2;
    // Reset values
    localparam logic [2:0]  CSEL_RESET = 3'h0;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    // Port states, one-hot
    typedef enum logic [2:0] {
        TIO_IDLE = 3'b001,
        TIO_HOLD = 3'b010,
        TIO_RUN  = 3'b100
    } tio_state_e;
endpackage

/* File: logic/tio_port.sv */
// Purpose: Timed I/O port with serialiser and clock blocks
// Assumes: Pins and strobe are synchronous to ref_clk
// Notes:   Avalon-MM slave, reads wait one cycle
// Behaviour
// R1 - Widths 1 to 32, one direction
// R2 - Drive pins, sample with optional condition
// R3 - Processor accesses finish in one cycle; reads here take one wait state
// R4 - Open drain: zero pulls, one floats
// R5 - Open drain chosen per whole port
// R6 - Serialiser plus transfer register buffer data
// R7 - Sixteen bit counter times transfers
// R8 - Counter readable at any time
// R9 - Hold transfer until counter meets target
// R10 - Timestamp stored on every transfer
// R11 - Enabled link disables overlapping port
// R12 - Narrower port owns shared pins
// R13 - Unshared wider pins remain usable
// R14 - Transfers always at full width
// R15 - Six clock blocks, first is reference
// R16 - Other blocks run at own rate
// R17 - One-bit pin may source clock block
// R18 - Pin clock optionally divided
// R19 - Input strobe qualifies incoming data
// R20 - Output strobe accompanies driven data
// R21 - After reset port uses block zero
// R22 - Pin conditions raise events, no interrupts
// R23 - Counter steps per tick, wraps
// R24 - All port actions on selected tick
`timescale 1ns/100ps
module tio_port (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Port pins
    input  wire logic [31:0] pin_in,
    output logic      [31:0] pin_out,
    output logic      [31:0] pin_oe_n,
    // Pin sharing
    input  wire logic [31:0] pin_taken,
    input  wire logic        link_en,
    // Clock source pin
    input  wire logic        clock_pin,
    // Strobes and events
    input  wire logic        strobe_input_qualifier,
    output logic             strobe_output_qualifier,
    output logic             port_event
);
    // Whole state of the port
    typedef struct packed {
        logic                   en;
        logic                   dir_out;
        logic                   od;
        logic [2:0]             wid;
        logic [2:0]             clk_sel;
        logic                   strobe_en;
        logic [1:0]             cond_mode;
        logic [31:0]            cond;
        logic [4:0][8:0]        clkcfg;
        tio_pkg::tio_state_e    state;
        logic [31:0]            sr;
        logic [31:0]            xfer;
        logic [5:0]             sc;
        logic [15:0]            count;
        logic [15:0]            target;
        logic [15:0]            stamp;
        logic                   armed;
        logic                   pend;
        logic                   valid;
        logic                   evt;
        logic [31:0]            pin_val;
        logic [31:0]            pin_out;
        logic [31:0]            pin_oe_n;
        logic                   strobe;
        logic                   event_out;
        logic                   rd_ack;
        logic [31:0]            readdata;
    } tio_port_s;

    tio_port_s   st;        // Registered state
    tio_port_s   next_st;   // Next state
    logic [5:0]  ticks;     // Tick per clock block
    logic        port_tick; // Selected tick, enabled
    logic        xfer_now;  // Transfer moment
    logic        time_ok;   // Timed hold satisfied
    logic        strobe_ok; // Input qualified
    logic [31:0] mask;      // Pins of this width
    logic [5:0]  wbits;     // Bits per tick
    logic [5:0]  nshift;    // Ticks per word
    logic [31:0] pins_m;    // Masked pin sample
    logic [63:0] shifted;   // Input shift helper
    logic [31:0] rd_mux;    // Read data select
    logic        cond_hit;  // Condition met
    logic        bus_wr;    // Write taken
    logic        bus_rd;    // Read taken

    // R15 block zero is the reference
    assign ticks[0] = 1'b1;

    // R16 five programmable blocks
    genvar g;
    generate
        for (g = 1; g < tio_pkg::NUM_CLKBLK; g++) begin : g_clk
            tio_clkblk u_clk (
                .ref_clk   (ref_clk),
                .reset     (reset),
                .src_pin   (st.clkcfg[g-1][tio_pkg::CLK_SRCPIN]),
                .divide    (st.clkcfg[g-1][7:0]),
                .clock_pin (clock_pin),
                .tick      (ticks[g])
            );
        end
    endgenerate

    // R1 R14 width decode, always full width
    always_comb begin
        unique case (st.wid)
            tio_pkg::WID_4:  begin mask = 32'h0000_000F; wbits = 6'h04; nshift = 6'h08; end
            tio_pkg::WID_8:  begin mask = 32'h0000_00FF; wbits = 6'h08; nshift = 6'h04; end
            tio_pkg::WID_16: begin mask = 32'h0000_FFFF; wbits = 6'h10; nshift = 6'h02; end
            tio_pkg::WID_32: begin mask = 32'hFFFF_FFFF; wbits = 6'h20; nshift = 6'h01; end
            default:         begin mask = 32'h0000_0001; wbits = 6'h01; nshift = 6'h20; end
        endcase
    end

    // R24 selected tick drives everything
    assign port_tick = st.en && !link_en && ticks[(st.clk_sel > 3'h5) ? 3'h0 : st.clk_sel];
    // R9 armed transfers wait for target
    assign time_ok   = !st.armed || (st.count == st.target);
    // R19 strobe gates sampling
    assign strobe_ok = !st.strobe_en || strobe_input_qualifier;
    assign pins_m    = pin_in & mask;
    assign shifted   = {pins_m, st.sr} >> wbits;
    assign cond_hit  = (st.cond_mode == tio_pkg::COND_EQ) ? (pins_m == (st.cond & mask))
                                                         : (pins_m != (st.cond & mask));
    assign bus_wr    = avs_write;
    assign bus_rd    = avs_read && !st.rd_ack;

    // Read data select
    always_comb begin
        rd_mux = tio_pkg::WORD_RESET;
        unique case (avs_address)
            tio_pkg::ADDR_CTRL:   rd_mux = {20'h00000, st.cond_mode, st.strobe_en, st.clk_sel,
                                            st.wid, st.od, st.dir_out, st.en};
            tio_pkg::ADDR_DATA:   rd_mux = st.xfer;
            tio_pkg::ADDR_TIME:   rd_mux = {16'h0000, st.target};
            // R8 live counter
            tio_pkg::ADDR_COUNT:  rd_mux = {16'h0000, st.count};
            tio_pkg::ADDR_STAMP:  rd_mux = {16'h0000, st.stamp};
            tio_pkg::ADDR_STATUS: rd_mux = {28'h0000000, st.state != tio_pkg::TIO_IDLE,
                                            st.evt, st.pend, st.valid};
            tio_pkg::ADDR_COND:   rd_mux = st.cond;
            8'h20, 8'h24, 8'h28, 8'h2C, 8'h30:
                rd_mux = {23'h000000, st.clkcfg[avs_address[4:2]]};
            default:              rd_mux = tio_pkg::WORD_RESET;
        endcase
    end

    // Next state: bus, then port, then bus writes
    always_comb begin
        next_st = st;
        next_st.event_out = 1'b0;
        next_st.strobe = 1'b0;
        next_st.rd_ack = 1'b0;
        xfer_now = 1'b0;
        // R3 read answered next cycle
        if (bus_rd) begin
            next_st.rd_ack = 1'b1;
            next_st.readdata = rd_mux;
            if (avs_address == tio_pkg::ADDR_DATA) begin
                next_st.valid = 1'b0;
            end
        end
        // Sticky event cleared by writing one
        if (bus_wr && avs_address == tio_pkg::ADDR_STATUS && avs_writedata[tio_pkg::STAT_EVENT]) begin
            next_st.evt = 1'b0;
        end
        if (port_tick) begin
            // R7 R23 counter wraps naturally
            next_st.count = st.count + 16'h0001;
            unique case (st.state)
                tio_pkg::TIO_IDLE, tio_pkg::TIO_HOLD: begin
                    if (!time_ok) begin
                        next_st.state = tio_pkg::TIO_HOLD;
                    end else if (st.dir_out) begin
                        if (st.pend) begin
                            // R6 R10 load serialiser, stamp
                            next_st.sr = st.xfer;
                            next_st.sc = nshift;
                            next_st.pend = 1'b0;
                            next_st.armed = 1'b0;
                            next_st.stamp = st.count;
                            next_st.state = tio_pkg::TIO_RUN;
                            xfer_now = 1'b1;
                        end
                    end else if (st.cond_mode != tio_pkg::COND_NONE) begin
                        // R2 R22 conditional sample raises event
                        if (cond_hit) begin
                            next_st.xfer = pins_m;
                            next_st.valid = 1'b1;
                            next_st.evt = 1'b1;
                            next_st.event_out = 1'b1;
                            next_st.stamp = st.count;
                            next_st.armed = 1'b0;
                            next_st.cond_mode = tio_pkg::COND_NONE;
                            next_st.state = tio_pkg::TIO_IDLE;
                            xfer_now = 1'b1;
                        end
                    end else begin
                        // Start deserialising
                        next_st.sc = nshift;
                        next_st.armed = 1'b0;
                        next_st.state = tio_pkg::TIO_RUN;
                    end
                end
                tio_pkg::TIO_RUN: begin
                    if (st.dir_out) begin
                        // R2 shift out one slice
                        next_st.pin_val = st.sr & mask;
                        next_st.sr = st.sr >> wbits;
                        // R20 strobe with data
                        next_st.strobe = st.strobe_en;
                        next_st.sc = st.sc - 6'h01;
                        if (st.sc == 6'h01) begin
                            next_st.state = tio_pkg::TIO_IDLE;
                        end
                    end else if (strobe_ok) begin
                        // R19 qualified input slice
                        next_st.sr = shifted[31:0];
                        next_st.sc = st.sc - 6'h01;
                        if (st.sc == 6'h01) begin
                            // R10 R22 word done
                            next_st.xfer = shifted[31:0];
                            next_st.valid = 1'b1;
                            next_st.evt = 1'b1;
                            next_st.event_out = 1'b1;
                            next_st.stamp = st.count;
                            next_st.sc = nshift;
                            xfer_now = 1'b1;
                        end
                    end
                end
                default: next_st.state = tio_pkg::TIO_IDLE;
            endcase
        end
        // Bus writes below win over port updates; a port event beats the event clear above
        if (bus_wr) begin
            unique case (avs_address)
                tio_pkg::ADDR_CTRL: begin
                    next_st.en        = avs_writedata[tio_pkg::CTRL_EN];
                    // R1 one direction per port
                    next_st.dir_out   = avs_writedata[tio_pkg::CTRL_DIR];
                    // R5 per-port open drain
                    next_st.od        = avs_writedata[tio_pkg::CTRL_OD];
                    next_st.wid       = avs_writedata[tio_pkg::CTRL_WID +: 3];
                    next_st.clk_sel   = avs_writedata[tio_pkg::CTRL_CSEL +: 3];
                    next_st.strobe_en = avs_writedata[tio_pkg::CTRL_STROBE];
                    next_st.cond_mode = avs_writedata[tio_pkg::CTRL_COND +: 2];
                    next_st.state     = tio_pkg::TIO_IDLE;
                    next_st.sc        = 6'h00;
                end
                tio_pkg::ADDR_DATA: begin
                    if (st.dir_out) begin
                        next_st.xfer = avs_writedata;
                        next_st.pend = 1'b1;
                    end
                end
                tio_pkg::ADDR_TIME: begin
                    // R9 arm next transfer
                    next_st.target = avs_writedata[15:0];
                    next_st.armed  = 1'b1;
                end
                tio_pkg::ADDR_COND: next_st.cond = avs_writedata;
                8'h20, 8'h24, 8'h28, 8'h2C, 8'h30:
                    next_st.clkcfg[avs_address[4:2]] = avs_writedata[8:0];
                default: next_st.en = st.en;
            endcase
        end
        // R11 R12 R13 pin ownership, R4 open drain
        next_st.pin_oe_n = ~({32{next_st.en && next_st.dir_out && !link_en}} & mask & ~pin_taken
                             & ~({32{next_st.od}} & next_st.pin_val));
        next_st.pin_out = next_st.pin_val & ~{32{next_st.od}};
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st <= '0;
            st.state <= tio_pkg::TIO_IDLE;
            // R21 reset onto block zero
            st.clk_sel <= tio_pkg::CSEL_RESET;
            st.pin_oe_n <= 32'hFFFF_FFFF;
        end else begin
            st <= next_st;
        end
    end

    // Outputs from flip-flops, except waitrequest, which comes from avs_read
    assign avs_readdata            = st.readdata;
    assign avs_waitrequest         = bus_rd;
    assign pin_out                 = st.pin_out;
    assign pin_oe_n                = st.pin_oe_n;
    assign strobe_output_qualifier = st.strobe;
    assign port_event              = st.event_out;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_read_stall;
        avs_read && avs_waitrequest;
    endsequence
    sequence s_read_done;
        !avs_waitrequest ##0 st.rd_ack;
    endsequence

    a_read_one_wait: assert property (s_read_stall |=> s_read_done) // R3
        else $error("read not answered after one wait");
    a_od_low_only: assert property (st.od |-> ((~pin_oe_n & (st.pin_val | pin_out)) == 32'h0000_0000)) // R4
        else $error("open drain drove a high");
    a_link_release: assert property (link_en |=> &pin_oe_n) // R11
        else $error("port drove pins under link");
    a_taken_release: assert property ((|pin_taken) |=> ((pin_oe_n & $past(pin_taken)) == $past(pin_taken))) // R12
        else $error("shared pin driven by wider port");
    a_count_step: assert property (port_tick |=> st.count == $past(st.count) + 16'h0001) // R23
        else $error("counter did not step");
    a_count_hold: assert property (!port_tick |=> $stable(st.count)) // R7
        else $error("counter moved without tick");
    a_stamp_take: assert property (xfer_now |=> st.stamp == $past(st.count)) // R10
        else $error("timestamp not captured");
    a_timed_xfer: assert property (xfer_now && st.armed |-> st.count == st.target) // R9
        else $error("timed transfer before target");
    a_strobe_dir: assert property (strobe_output_qualifier |-> $past(st.dir_out) && $past(port_tick)) // R20
        else $error("output strobe without output tick");
    a_event_set: assert property (port_event |-> st.evt && st.valid) // R22
        else $error("event without sticky status");
    a_reset_block0: assert property ($past(reset) |-> st.clk_sel == 3'h0) // R21
        else $error("clock select not zero after reset");
endmodule
